// >>> fb_mask_clear.sv
// Framebuffer write masking and clear engine with an AXI4-Lite register slave
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "fb_mask_regs.svh"
module fb_mask_clear
  import fb_mask_pkg::*;
#(
  parameter int         SLOTS   = 4,
  parameter int         IW      = 8,
  parameter int         SW      = 8,
  parameter logic [3:0] PRESENT = 4'hF
)
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  // AXI4-Lite write
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Fragment writes
  input  wire logic                     frag_valid,
  output logic                          frag_ready,
  input  wire logic [$clog2(SLOTS)-1:0] frag_slot,
  input  wire logic                     frag_back_face,
  input  wire logic                     frag_resolve,
  input  wire logic [31:0]              frag_colour,
  input  wire logic [23:0]              frag_depth,
  input  wire logic [SW-1:0]            frag_stencil,
  // Masked writes toward memory
  output logic                          pix_valid,
  output logic                          pix_is_clear,
  output logic [3:0]                    pix_targets,
  output logic [31:0]                   pix_colour,
  output logic [31:0]                   pix_colour_we,
  output logic [23:0]                   pix_depth,
  output logic                          pix_depth_we,
  output logic [SW-1:0]                 pix_stencil,
  output logic [SW-1:0]                 pix_stencil_we,
  output logic [63:0]                   pix_accum,
  output logic                          pix_accum_we
);

  localparam int SIW = $clog2(SLOTS);

  // ****************************************
  // State
  // ****************************************
  logic [3:0]           ctrl_ff;
  logic [IW-1:0]        index_mask_ff;
  logic [3:0]           comp_en_ff [SLOTS];
  logic [3:0]           target_ff  [SLOTS];
  logic                 depth_we_ff;
  logic [SW-1:0]        sten_front_ff;
  logic [SW-1:0]        sten_back_ff;
  logic [15:0]          col_clr_ff [4];
  logic [15:0]          acc_clr_ff [4];
  logic [IW-1:0]        idx_clr_ff;
  logic [15:0]          dep_clr_ff;
  logic [SW-1:0]        sten_clr_ff;
  logic [31:0]          one_data0_ff;
  logic [31:0]          one_data1_ff;
  logic [1:0]           err_ff;
  clear_state_e         clr_state_ff;
  logic [3:0]           clr_set_ff;
  logic                 clr_one_ff;
  logic [SIW-1:0]       clr_slot_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 rvalid_ff;
  logic [31:0]          rdata_ff;
  logic [1:0]           rresp_ff;

  // ****************************************
  // Fixed-point and register-map helpers
  // ****************************************
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo);
    if ($signed(v) > $signed(`FIX_ONE))
      return `FIX_ONE;
    else if ($signed(v) < $signed(lo))
      return lo;
    else
      return v;
  endfunction

  // Q2.14 in [-1,1] or [0,1] to an 8-bit normalized channel, rounded
  function automatic logic [7:0] to_norm8(input logic [15:0] v, input logic snorm);
    logic [15:0] c;
    logic [31:0] p;
    c = clamp(v, snorm ? `FIX_MINUS_ONE : `FIX_ZERO);
    p = snorm ? 32'($signed(c) * 127) : 32'(c * 255);
    p = 32'($signed(p) + 32'sh0000_2000);
    return p[21:14];
  endfunction

  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `OFS_CTRL:        v = {28'h000_0000, ctrl_ff};
      `OFS_INDEX_MASK:  v = 32'(index_mask_ff);
      `OFS_ALL_EN:      v = {28'h000_0000, comp_en_ff[0]};
      `OFS_SLOT_EN:     for (int i = 0; i < SLOTS; i++) v[4*i +: 4] = comp_en_ff[i];
      `OFS_DEPTH_WE:    v = {31'h0000_0000, depth_we_ff};
      `OFS_STEN_BOTH:   v = 32'(sten_front_ff);
      `OFS_STEN_FACE:   v = {8'h00, 8'(sten_back_ff), 8'h00, 8'(sten_front_ff)};
      `OFS_COL_CLR_RG:  v = {col_clr_ff[1], col_clr_ff[0]};
      `OFS_COL_CLR_BA:  v = {col_clr_ff[3], col_clr_ff[2]};
      `OFS_IDX_CLR:     v = 32'(idx_clr_ff);
      `OFS_DEP_CLR:     v = {16'h0000, dep_clr_ff};
      `OFS_STEN_CLR:    v = 32'(sten_clr_ff);
      `OFS_ACC_CLR_RG:  v = {acc_clr_ff[1], acc_clr_ff[0]};
      `OFS_ACC_CLR_BA:  v = {acc_clr_ff[3], acc_clr_ff[2]};
      `OFS_CLEAR_CMD:   v = {31'h0000_0000, clr_state_ff == CLR_ISSUE};
      `OFS_CLEAR_ONE:   v = {31'h0000_0000, clr_state_ff == CLR_ISSUE};
      `OFS_ONE_DATA0:   v = one_data0_ff;
      `OFS_ONE_DATA1:   v = one_data1_ff;
      `OFS_SLOT_TARGET: for (int i = 0; i < SLOTS; i++) v[4*i +: 4] = target_ff[i];
      `OFS_ERR:         v = {30'h0000_0000, err_ff};
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `OFS_ERR);
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Address and data are taken together, so neither can be lost while the other waits
  logic        wr_go;
  logic [31:0] wr_val;
  logic [7:0]  wa;
  assign wa            = s_axi_awaddr;
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb
  begin
    wr_val = reg_value(wa);
    for (int b = 0; b < 4; b++)
      if (s_axi_wstrb[b])
        wr_val[8*b +: 8] = s_axi_wdata[8*b +: 8];
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= reg_value(s_axi_araddr);
      rresp_ff  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ****************************************
  // Mask registers
  // ****************************************
  logic [3:0] wsel_slot;
  assign wsel_slot = 4'(wr_val[9:8]);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrl_ff       <= 4'h0;
      index_mask_ff <= '1;
      depth_we_ff   <= 1'b1;
      sten_front_ff <= '1;
      sten_back_ff  <= '1;
      for (int i = 0; i < SLOTS; i++)
      begin
        comp_en_ff[i] <= 4'hF;
        target_ff[i]  <= (i == 0) ? `RST_SLOT0_TARGET : 4'h0;
      end
    end
    else if (wr_go)
    begin
      // Each command lands in one edge, so later pixels see all of it
      case (wa)
        `OFS_CTRL:       ctrl_ff <= wr_val[3:0];
        `OFS_INDEX_MASK: index_mask_ff <= wr_val[IW-1:0];
        `OFS_ALL_EN:
          for (int i = 0; i < SLOTS; i++)
            comp_en_ff[i] <= wr_val[3:0];
        `OFS_SLOT_EN:
          if (32'(wsel_slot) < SLOTS)
            comp_en_ff[wsel_slot[SIW-1:0]] <= wr_val[3:0];
        `OFS_DEPTH_WE:   depth_we_ff <= |wr_val;
        `OFS_STEN_BOTH:
        begin
          sten_front_ff <= wr_val[SW-1:0];
          sten_back_ff  <= wr_val[SW-1:0];
        end
        `OFS_STEN_FACE:
        begin
          if (wr_val[16])
            sten_front_ff <= wr_val[SW-1:0];
          if (wr_val[17])
            sten_back_ff <= wr_val[SW-1:0];
        end
        `OFS_SLOT_TARGET:
          for (int i = 0; i < SLOTS; i++)
            target_ff[i] <= wr_val[4*i +: 4];
        default:
          ;
      endcase
    end
  end

  // ****************************************
  // Clear values
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        col_clr_ff[i] <= `FIX_ZERO;
        acc_clr_ff[i] <= `FIX_ZERO;
      end
      idx_clr_ff   <= '0;
      dep_clr_ff   <= `RST_DEP_CLR;
      sten_clr_ff  <= '0;
      one_data0_ff <= 32'h0000_0000;
      one_data1_ff <= 32'h0000_0000;
    end
    else if (wr_go)
    begin
      case (wa)
        `OFS_COL_CLR_RG: {col_clr_ff[1], col_clr_ff[0]} <= wr_val;
        `OFS_COL_CLR_BA: {col_clr_ff[3], col_clr_ff[2]} <= wr_val;
        `OFS_IDX_CLR:    idx_clr_ff <= wr_val[IW-1:0];
        `OFS_DEP_CLR:    dep_clr_ff <= clamp(wr_val[15:0], `FIX_ZERO);
        `OFS_STEN_CLR:   sten_clr_ff <= wr_val[SW-1:0];
        `OFS_ACC_CLR_RG:
        begin
          acc_clr_ff[0] <= clamp(wr_val[15:0], `FIX_MINUS_ONE);
          acc_clr_ff[1] <= clamp(wr_val[31:16], `FIX_MINUS_ONE);
        end
        `OFS_ACC_CLR_BA:
        begin
          acc_clr_ff[2] <= clamp(wr_val[15:0], `FIX_MINUS_ONE);
          acc_clr_ff[3] <= clamp(wr_val[31:16], `FIX_MINUS_ONE);
        end
        `OFS_ONE_DATA0:  one_data0_ff <= wr_val;
        `OFS_ONE_DATA1:  one_data1_ff <= wr_val;
        default:
          ;
      endcase
    end
  end

  // ****************************************
  // Clear commands and errors
  // ****************************************
  logic       cmd_clear;
  logic       cmd_one;
  logic       cmd_bad_val;
  logic       cmd_bad_op;
  one_kind_e  one_kind;
  logic [3:0] one_slot;
  logic       busy;

  assign busy      = clr_state_ff == CLR_ISSUE;
  assign one_kind  = one_kind_e'(wr_val[1:0]);
  assign one_slot  = wr_val[7:4];
  assign cmd_clear = wr_go && wa == `OFS_CLEAR_CMD;
  assign cmd_one   = wr_go && wa == `OFS_CLEAR_ONE;

  always_comb
  begin
    cmd_bad_val = 1'b0;
    cmd_bad_op  = 1'b0;
    if (cmd_clear)
      cmd_bad_val = |wr_val[31:4];
    else if (cmd_one)
    begin
      if (one_kind == ONE_COLOUR)
      begin
        cmd_bad_val = 32'(one_slot) >= SLOTS;
        cmd_bad_op  = !cmd_bad_val && ctrl_ff[`CTRL_INDEX_MODE];
      end
      else
        cmd_bad_val = one_slot != 4'h0;
    end
    else if (wr_go && wa == `OFS_SLOT_EN)
      cmd_bad_val = 32'(wsel_slot) >= SLOTS;
  end

  // Errors are sticky, cleared by writing one; a new error in the same cycle wins
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      err_ff <= 2'b00;
    else
    begin
      err_ff <= (err_ff & ~((wr_go && wa == `OFS_ERR) ? wr_val[1:0] : 2'b00))
                | {cmd_bad_op, cmd_bad_val};
    end
  end

  // A command written while a clear is still issuing is dropped
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      clr_state_ff <= CLR_IDLE;
      clr_set_ff   <= 4'h0;
      clr_one_ff   <= 1'b0;
      clr_slot_ff  <= '0;
    end
    else
    begin
      case (clr_state_ff)
        CLR_IDLE:
          if (cmd_clear && !cmd_bad_val && |wr_val[3:0])
          begin
            clr_state_ff <= CLR_ISSUE;
            clr_set_ff   <= wr_val[3:0];
            clr_one_ff   <= 1'b0;
            clr_slot_ff  <= '0;
          end
          else if (cmd_one && !cmd_bad_val && !cmd_bad_op)
          begin
            clr_state_ff <= CLR_ISSUE;
            clr_one_ff   <= 1'b1;
            clr_slot_ff  <= one_slot[SIW-1:0];
            case (one_kind)
              ONE_COLOUR:  clr_set_ff <= 4'h1;
              ONE_DEPTH:   clr_set_ff <= 4'h2;
              ONE_STENCIL: clr_set_ff <= 4'h4;
              default:     clr_set_ff <= 4'h6;
            endcase
          end
        CLR_ISSUE:
          // A full colour clear walks every slot, one beat each
          if (clr_one_ff || !clr_set_ff[`CLR_BIT_COLOUR] || 32'(clr_slot_ff) == SLOTS - 1)
            clr_state_ff <= CLR_IDLE;
          else
            clr_slot_ff <= SIW'(clr_slot_ff + 1'b1);
        default:
          clr_state_ff <= CLR_IDLE;
      endcase
    end
  end

  // ****************************************
  // Write enable generation
  // ****************************************
  logic [SIW-1:0] use_slot;
  logic [31:0]    slot_bit_we;
  assign use_slot   = busy ? clr_slot_ff : frag_slot;
  assign frag_ready = !busy;

  bit_enable_expand #(
    .IW (IW)
  ) u_expand (
    .index_mode (ctrl_ff[`CTRL_INDEX_MODE]),
    .comp_en    (comp_en_ff[use_slot]),
    .index_mask (index_mask_ff),
    .bit_we     (slot_bit_we)
  );

  // Clear payload, from the stored values or from the per-buffer data words
  logic [15:0]   c_col [4];
  logic [31:0]   clr_colour;
  logic [15:0]   c_dep;
  logic [23:0]   clr_depth;
  logic [SW-1:0] c_sten;
  logic          beat0;

  always_comb
  begin
    c_col[0] = clr_one_ff ? one_data0_ff[15:0] : col_clr_ff[0];
    c_col[1] = clr_one_ff ? one_data0_ff[31:16] : col_clr_ff[1];
    c_col[2] = clr_one_ff ? one_data1_ff[15:0] : col_clr_ff[2];
    c_col[3] = clr_one_ff ? one_data1_ff[31:16] : col_clr_ff[3];
    for (int i = 0; i < 4; i++)
      clr_colour[8*i +: 8] = to_norm8(c_col[i], ctrl_ff[`CTRL_COL_SNORM]);
    if (ctrl_ff[`CTRL_INDEX_MODE])
      clr_colour = 32'(idx_clr_ff);
    c_dep = clr_one_ff ? clamp(one_data0_ff[15:0], `FIX_ZERO) : dep_clr_ff;
    if (ctrl_ff[`CTRL_DEPTH_FLOAT])
      clr_depth = {8'h00, c_dep};
    else
      clr_depth = 24'(({8'h00, c_dep} * 40'h00_00FF_FFFF) >> 14);
    c_sten = clr_one_ff ? one_data1_ff[SW-1:0] : sten_clr_ff;
  end

  assign beat0 = clr_one_ff || clr_slot_ff == '0;

  // ****************************************
  // Masked write output
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pix_valid      <= 1'b0;
      pix_is_clear   <= 1'b0;
      pix_targets    <= 4'h0;
      pix_colour     <= 32'h0000_0000;
      pix_colour_we  <= 32'h0000_0000;
      pix_depth      <= 24'h00_0000;
      pix_depth_we   <= 1'b0;
      pix_stencil    <= '0;
      pix_stencil_we <= '0;
      pix_accum      <= 64'h0000_0000_0000_0000;
      pix_accum_we   <= 1'b0;
    end
    else if (busy)
    begin
      pix_valid    <= 1'b1;
      pix_is_clear <= 1'b1;
      pix_targets  <= target_ff[clr_slot_ff];
      pix_colour   <= clr_colour;
      // Only the masks and pass-through stages act on clear data
      pix_colour_we  <= (clr_set_ff[`CLR_BIT_COLOUR] && PRESENT[`CLR_BIT_COLOUR])
                        ? slot_bit_we : 32'h0000_0000;
      pix_depth      <= clr_depth;
      pix_depth_we   <= beat0 && clr_set_ff[`CLR_BIT_DEPTH] && PRESENT[`CLR_BIT_DEPTH]
                        && depth_we_ff;
      pix_stencil    <= c_sten;
      pix_stencil_we <= (beat0 && clr_set_ff[`CLR_BIT_STENCIL] && PRESENT[`CLR_BIT_STENCIL])
                        ? sten_front_ff : '0;
      pix_accum      <= {acc_clr_ff[3], acc_clr_ff[2], acc_clr_ff[1], acc_clr_ff[0]};
      pix_accum_we   <= beat0 && clr_set_ff[`CLR_BIT_ACCUM] && PRESENT[`CLR_BIT_ACCUM];
    end
    else
    begin
      pix_valid    <= frag_valid;
      pix_is_clear <= 1'b0;
      pix_targets  <= target_ff[frag_slot];
      pix_colour   <= frag_colour;
      // Resolve writes replace the selected buffers whatever the enables say
      if (frag_resolve && ctrl_ff[`CTRL_MS_ONE])
        pix_colour_we <= 32'hFFFF_FFFF;
      else
        pix_colour_we <= slot_bit_we;
      pix_depth      <= frag_depth;
      pix_depth_we   <= frag_valid && depth_we_ff;
      pix_stencil    <= frag_stencil;
      pix_stencil_we <= frag_back_face ? sten_back_ff : sten_front_ff;
      pix_accum      <= 64'h0000_0000_0000_0000;
      pix_accum_we   <= 1'b0;
    end
  end

endmodule

// >>> fb_mask_regs.svh
// Register offsets, field positions, reset values and number formats of the mask/clear block
`ifndef FB_MASK_REGS_SVH
`define FB_MASK_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL          8'h00
`define OFS_INDEX_MASK    8'h04
`define OFS_ALL_EN        8'h08
`define OFS_SLOT_EN       8'h0C
`define OFS_DEPTH_WE      8'h10
`define OFS_STEN_BOTH     8'h14
`define OFS_STEN_FACE     8'h18
`define OFS_COL_CLR_RG    8'h1C
`define OFS_COL_CLR_BA    8'h20
`define OFS_IDX_CLR       8'h24
`define OFS_DEP_CLR       8'h28
`define OFS_STEN_CLR      8'h2C
`define OFS_ACC_CLR_RG    8'h30
`define OFS_ACC_CLR_BA    8'h34
`define OFS_CLEAR_CMD     8'h38
`define OFS_CLEAR_ONE     8'h3C
`define OFS_ONE_DATA0     8'h40
`define OFS_ONE_DATA1     8'h44
`define OFS_SLOT_TARGET   8'h48
`define OFS_ERR           8'h4C

// ****************************************
// Fields
// ****************************************
`define CTRL_INDEX_MODE   0
`define CTRL_MS_ONE       1
`define CTRL_DEPTH_FLOAT  2
`define CTRL_COL_SNORM    3
`define CLR_BIT_COLOUR    0
`define CLR_BIT_DEPTH     1
`define CLR_BIT_STENCIL   2
`define CLR_BIT_ACCUM     3
`define ERR_INVALID_VALUE 0
`define ERR_INVALID_OP    1

// ****************************************
// Values: clear numbers are signed Q2.14
// ****************************************
`define FIX_ONE           16'h4000
`define FIX_MINUS_ONE     16'hC000
`define FIX_ZERO          16'h0000
`define RST_DEP_CLR       16'h4000
`define RST_SLOT0_TARGET  4'h1
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// >>> fb_mask_pkg.sv
// Types shared by the mask/clear block
package fb_mask_pkg;

  typedef enum logic [1:0] {ONE_COLOUR, ONE_DEPTH, ONE_STENCIL, ONE_DEPTH_STENCIL} one_kind_e;
  typedef enum logic [1:0] {FACE_NONE, FACE_FRONT, FACE_BACK, FACE_BOTH} face_e;
  typedef enum {CLR_IDLE, CLR_ISSUE} clear_state_e;

endpackage

// >>> bit_enable_expand.sv
// Turns component enables or the index mask into per-bit colour write enables
`timescale 1ns/10ps
module bit_enable_expand
  import fb_mask_pkg::*;
#(
  parameter int IW = 8
)
(
  // Mask state
  input  wire logic          index_mode,
  input  wire logic [3:0]    comp_en,
  input  wire logic [IW-1:0] index_mask,
  // Result
  output logic      [31:0]   bit_we
);

  logic [31:0] rgba_we;

  genvar c;
  generate
    for (c = 0; c < 4; c++)
    begin : g_comp
      assign rgba_we[8*c +: 8] = {8{comp_en[c]}};
    end
  endgenerate

  // The index mask only matters in index mode, in RGBA mode it is ignored
  assign bit_we = index_mode ? {{(32-IW){1'b0}}, index_mask} : rgba_we;

endmodule

// >>> fb_mask_clear_monitor.sv
// Timing checker for the mask and clear block
`timescale 1ns/10ps
module fb_mask_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Fragments and pixels
  input wire logic        frag_valid,
  input wire logic        frag_ready,
  input wire logic        pix_valid,
  input wire logic        pix_is_clear
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_wr;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rd;
    s_axi_arvalid && !s_axi_rvalid |-> s_axi_arready ##1 s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read not taken");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_frag;
    frag_valid && frag_ready |=> pix_valid && !pix_is_clear;
  endproperty
  a_frag: assert property (p_frag) else $error("no pixel write");
  property p_src;
    pix_valid && !pix_is_clear |-> $past(frag_valid && frag_ready);
  endproperty
  a_src: assert property (p_src) else $error("pixel without fragment");
  property p_clr;
    !frag_ready |=> pix_valid && pix_is_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("clear beat missing");
  property p_arbusy;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_arbusy: assert property (p_arbusy) else $error("rvalid stuck");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_frag: cover property (frag_valid && frag_ready);
  c_clr: cover property (pix_valid && pix_is_clear);
endmodule

bind fb_mask_clear fb_mask_checker u_chk (.*);

// >>> tb_fb_mask_clear.sv
// Self-checking testbench for the mask and clear block
`timescale 1ns/10ps
`include "fb_mask_regs.svh"
module tb_fb_mask_clear import fb_mask_pkg::*;;
  logic core_clk = '0, nrst = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, frag_valid = '0, frag_back_face = '0;
  logic frag_resolve = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, frag_ready, pix_valid, pix_is_clear, pix_depth_we, pix_accum_we;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, frag_stencil = '0, pix_stencil;
  logic [7:0] pix_stencil_we, sw;
  logic [31:0] s_axi_wdata = '0, frag_colour = '0, s_axi_rdata, pix_colour, pix_colour_we, v;
  logic [3:0] s_axi_wstrb = 4'hF, pix_targets;
  logic [1:0] s_axi_bresp, s_axi_rresp, frag_slot = '0, r;
  logic [23:0] frag_depth = '0, pix_depth;
  logic [63:0] pix_accum;
  int err_total = 0, check_count = 0;
  fb_mask_clear DUT (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task cyc;
    @(posedge core_clk);
    #1;
  endtask
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Write and read hold valid until the edge that sees ready high
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    #1;
    while (!s_axi_awready) cyc;
    @(posedge core_clk);
    s_axi_awvalid <= '0;
    s_axi_wvalid <= '0;
    s_axi_bready <= 1'h1;
    #1;
    while (!s_axi_bvalid) cyc;
    r = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= '0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    #1;
    while (!s_axi_arready) cyc;
    @(posedge core_clk);
    s_axi_arvalid <= '0;
    s_axi_rready <= 1'h1;
    #1;
    while (!s_axi_rvalid) cyc;
    chk(s_axi_rdata, e);
    @(posedge core_clk);
    s_axi_rready <= '0;
  endtask
  task frag(input logic [1:0] s, input logic b);
    @(posedge core_clk);
    frag_slot <= s;
    frag_back_face <= b;
    frag_valid <= 1'h1;
    #1;
    while (!frag_ready) cyc;
    @(posedge core_clk);
    frag_valid <= '0;
    #1;
    chk(pix_valid, 1'h1);
  endtask
  task t_reset;
    rdc(`OFS_INDEX_MASK, 32'h0000_00FF);
    rdc(`OFS_SLOT_EN, 32'h0000_FFFF);
    rdc(`OFS_DEPTH_WE, 32'h0000_0001);
    rdc(`OFS_STEN_FACE, 32'h00FF_00FF);
    rdc(`OFS_DEP_CLR, 32'h0000_4000);
    rdc(`OFS_SLOT_TARGET, 32'h0000_0001);
    $display("reset values done");
  endtask
  task t_mask;
    wr(`OFS_SLOT_TARGET, 32'h0000_0061);
    wr(`OFS_SLOT_EN, 32'h0000_0105);
    frag(2'h1, '0);
    chk(pix_colour_we, 32'h00FF_00FF);
    chk(pix_targets, 32'h0000_0006);
    frag(2'h2, '0);
    chk(pix_targets, '0);
    wr(`OFS_ALL_EN, 32'h0000_0003);
    frag(2'h1, '0);
    chk(pix_colour_we, 32'h0000_FFFF);
    wr(`OFS_DEPTH_WE, '0);
    frag(2'h0, '0);
    chk(pix_depth_we, '0);
    wr(8'h80, '0);
    chk(r, `RESP_SLVERR);
    $display("masks done");
  endtask
  task t_sten;
    wr(`OFS_STEN_FACE, 32'h0002_000F);
    frag(2'h0, 1'h1);
    chk(pix_stencil_we, 32'h0000_000F);
    frag(2'h0, '0);
    chk(pix_stencil_we, 32'h0000_00FF);
    fork
      wr(`OFS_CLEAR_CMD, 32'h0000_0004);
      begin
        cyc;
        while (!(pix_valid && pix_is_clear)) cyc;
        sw = pix_stencil_we;
      end
    join
    chk(sw, 32'h0000_00FF);
    wr(`OFS_CLEAR_CMD, 32'h0000_0010);
    rdc(`OFS_ERR, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0001);
    wr(`OFS_INDEX_MASK, 32'h0000_003C);
    frag(2'h0, '0);
    chk(pix_colour_we, 32'h0000_003C);
    wr(`OFS_CTRL, '0);
    frag(2'h0, '0);
    chk(pix_colour_we, 32'h0000_FFFF);
    $display("stencil and index done");
  endtask
  task t_clear;
    wr(`OFS_COL_CLR_RG, 32'h2000_4000);
    wr(`OFS_ACC_CLR_RG, 32'h8000_7000);
    rdc(`OFS_ACC_CLR_RG, 32'hC000_4000);
    wr(`OFS_DEP_CLR, 32'h0000_7000);
    rdc(`OFS_DEP_CLR, 32'h0000_4000);
    wr(`OFS_CTRL, 32'h0000_0004);
    fork
      wr(`OFS_CLEAR_CMD, 32'h0000_000B);
      begin
        cyc;
        while (!(pix_valid && pix_is_clear)) cyc;
        v = pix_colour;
        chk(pix_depth, 32'h0000_4000);
        chk(pix_accum[31:0], 32'hC000_4000);
        chk(pix_accum_we, 1'h1);
        chk(pix_targets, 32'h0000_0001);
      end
    join
    chk(v, 32'h0000_80FF);
    wr(`OFS_ERR, 32'h0000_0003);
    wr(`OFS_CLEAR_ONE, 32'h0000_0041);
    rdc(`OFS_ERR, 32'h0000_0001);
    wr(`OFS_ERR, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0001);
    wr(`OFS_CLEAR_ONE, 32'h0000_0000);
    rdc(`OFS_ERR, 32'h0000_0002);
    wr(`OFS_CTRL, 32'h0000_0002);
    wr(`OFS_ALL_EN, 32'h0000_0000);
    frag_resolve <= 1'h1;
    frag(2'h0, '0);
    chk(pix_colour_we, 32'hFFFF_FFFF);
    frag_resolve <= '0;
    $display("clears done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs under two hundred cycles; this only cuts a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    stop_test;
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    t_reset;
    t_mask;
    t_sten;
    t_clear;
    stop_test;
  end
endmodule
